// ### src/dual_comparator_control.sv
// register and mismatch logic for two analog comparators, avalon-mm slave
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dual_cmp_defines.svh"
// Function
// [RULE1] enable bit at top of control register
// [RULE2] result bit reads polarity-adjusted comparator output
// [RULE3] pin drive enable routes result to pin
// [RULE4] invert bit flips readable and pin result
// [RULE5] speed bit selects fast or low power
// [RULE6] reference bit picks internal path or pin
// [RULE7] two-bit field picks one of four pins
// [RULE8] pin driven only if drive, enable, output
// [RULE9] second comparator register mirrors first layout
// [RULE10] shared register mirrors both results, top bits
// [RULE11] mirror reads leave mismatch latches untouched
// [RULE12] per-comparator bit picks programmable or fixed reference
// [RULE13] shared register low four bits read zero
// [RULE14] analog-configured pins read zero on port
// [RULE15] reset clears all three registers
// [RULE16] control register read or write captures latch
// [RULE17] per-cycle latch; flag on mismatch edge
// [RULE18] disabled comparator result follows invert bit
// [RULE19] raw result passes two-flop synchroniser first
module dual_comparator_control
    import dual_cmp_pkg::*;
(
    input  wire logic        core_clk,          // system clock, 100 MHz
    input  wire logic        rstn,              // synchronous reset, active low
    input  wire logic [7:0]  avs_address,       // byte address
    input  wire logic        avs_read,          // read request
    input  wire logic        avs_write,         // write request
    input  wire logic [31:0] avs_writedata,     // write data, low byte used
    input  wire logic [3:0]  avs_byteenable,    // byte lanes
    output logic      [31:0] avs_readdata,      // read data, from flops
    output logic             avs_waitrequest,   // stall, combinational
    input  wire logic [1:0]  cmp_raw,           // asynchronous analog outputs
    output cmp_cfg_s         cfg_one,           // first comparator settings
    output cmp_cfg_s         cfg_two,           // second comparator settings
    input  wire logic [1:0]  pin_in,            // comparator output pins, input side
    output logic      [1:0]  pin_out,           // comparator output pins, drive level
    output logic      [1:0]  pin_oe,            // comparator output pins, enable
    output logic             irq                // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    cmp_ctrl_s   ctrl_reg [2];      // both control registers, same layout
    logic [1:0]  refsel_reg;        // [0] first, [1] second
    logic [1:0]  irq_status_reg;
    logic [1:0]  irq_mask_reg;
    logic [1:0]  dir_reg;           // 1 = pin is input
    logic [1:0]  analog_reg;        // 1 = pin is analog
    logic [1:0]  raw_meta_reg;
    logic [1:0]  raw_sync_reg;
    logic [1:0]  pin_meta_reg;
    logic [1:0]  pin_sync_reg;
    logic [1:0]  read_latch_reg;
    logic [1:0]  sample_latch_reg;
    logic [1:0]  mismatch_d_reg;
    logic [1:0]  pin_out_reg;
    logic [1:0]  pin_oe_reg;
    logic        ack_reg;
    logic [31:0] readdata_reg;

    logic [1:0]  result;
    logic [1:0]  mismatch;
    logic [1:0]  irq_event;
    logic        request;
    logic        accept;
    logic        wr_lane;
    logic [1:0]  ctrl_access;
    logic [1:0]  port_value;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // control register image as software sees it
    function automatic logic [7:0] ctrl_image(input cmp_ctrl_s c, input logic res);
        logic [7:0] v;
        v = 8'h00;
        v[`CMP_BIT_ENABLE]     = c.enable;              // RULE1
        v[`CMP_BIT_RESULT]     = res;                   // RULE2
        v[`CMP_BIT_PIN_DRIVE]  = c.pin_drive_enable;    // RULE3
        v[`CMP_BIT_INVERT]     = c.invert;              // RULE4
        v[`CMP_BIT_SPEED]      = c.speed_sel;           // RULE5
        v[`CMP_BIT_NONINV_SRC] = c.noninv_src_sel;      // RULE6
        v[`CMP_BIT_CHAN_HI:`CMP_BIT_CHAN_LO] = c.inv_channel_sel;   // RULE7
        return v;
    endfunction

    // written byte back into fields; the result bit is read-only
    function automatic cmp_ctrl_s ctrl_fields(input logic [7:0] v);
        cmp_ctrl_s c;
        c.enable           = v[`CMP_BIT_ENABLE];        // RULE1
        c.pin_drive_enable = v[`CMP_BIT_PIN_DRIVE];     // RULE3
        c.invert           = v[`CMP_BIT_INVERT];        // RULE4
        c.speed_sel        = v[`CMP_BIT_SPEED];         // RULE5
        c.noninv_src_sel   = v[`CMP_BIT_NONINV_SRC];    // RULE6
        c.inv_channel_sel  = v[`CMP_BIT_CHAN_HI:`CMP_BIT_CHAN_LO]; // RULE7
        return c;
    endfunction

    // polarity-adjusted result; a disabled comparator shows its invert bit
    function automatic logic adjusted(input cmp_ctrl_s c, input logic raw);
        return c.enable ? (raw ^ c.invert) : c.invert;  // RULE2 RULE4 RULE18
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: every access stalls one cycle so read data can be flopped
    assign request         = avs_read | avs_write;
    assign avs_waitrequest = request & ~ack_reg;
    assign accept          = request & ack_reg;
    assign wr_lane         = avs_write & accept & avs_byteenable[0];
    assign avs_readdata    = readdata_reg;

    // control register touched (read or write) this accept
    always_comb begin
        ctrl_access    = 2'b00;
        ctrl_access[0] = accept && (avs_address == `CMP_OFS_CTRL_ONE);
        ctrl_access[1] = accept && (avs_address == `CMP_OFS_CTRL_TWO);
    end

    // ack pulses one cycle after a request appears, then drops
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= request & ~ack_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers: first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            raw_meta_reg <= 2'b00;
            raw_sync_reg <= 2'b00;
            pin_meta_reg <= 2'b00;
            pin_sync_reg <= 2'b00;
        end else begin
            raw_meta_reg <= cmp_raw;            // RULE19
            raw_sync_reg <= raw_meta_reg;       // RULE19
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // readable result for each comparator
    always_comb begin
        result[0] = adjusted(ctrl_reg[0], raw_sync_reg[0]);
        result[1] = adjusted(ctrl_reg[1], raw_sync_reg[1]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers, one loop keeps both layouts identical
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl_reg[0] <= cmp_ctrl_s'(`CMP_RST_CTRL);      // RULE15
            ctrl_reg[1] <= cmp_ctrl_s'(`CMP_RST_CTRL);      // RULE15
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ctrl_access[i] && wr_lane) begin
                    ctrl_reg[i] <= ctrl_fields(avs_writedata[7:0]);  // RULE9
                end
            end
        end
    end

    // shared reference select bits
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            refsel_reg <= `CMP_RST_REFSEL;                  // RULE15
        end else if (wr_lane && avs_address == `CMP_OFS_MIRROR) begin
            refsel_reg[0] <= avs_writedata[`CMP_BIT_REFSEL_ONE];    // RULE12
            refsel_reg[1] <= avs_writedata[`CMP_BIT_REFSEL_TWO];    // RULE12
        end
    end

    // pin direction and analog selection; pins start as analog inputs
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dir_reg    <= `CMP_RST_DIR;
            analog_reg <= `CMP_RST_ANALOG;
        end else if (wr_lane && avs_address == `CMP_OFS_PIN_CFG) begin
            dir_reg    <= avs_writedata[`CMP_BIT_DIR_LO +: 2];
            analog_reg <= avs_writedata[`CMP_BIT_ANALOG_LO +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog settings, straight from the registers
    always_comb begin
        cfg_one.enable          = ctrl_reg[0].enable;           // RULE1
        cfg_one.speed_sel       = ctrl_reg[0].speed_sel;        // RULE5
        cfg_one.noninv_src_sel  = ctrl_reg[0].noninv_src_sel;   // RULE6
        cfg_one.ref_source_sel  = refsel_reg[0];                // RULE12
        cfg_one.inv_channel_sel = ctrl_reg[0].inv_channel_sel;  // RULE7
        cfg_two.enable          = ctrl_reg[1].enable;           // RULE1
        cfg_two.speed_sel       = ctrl_reg[1].speed_sel;        // RULE5
        cfg_two.noninv_src_sel  = ctrl_reg[1].noninv_src_sel;   // RULE6
        cfg_two.ref_source_sel  = refsel_reg[1];                // RULE12
        cfg_two.inv_channel_sel = ctrl_reg[1].inv_channel_sel;  // RULE7
    end

    // pin drive, flopped so the pin never glitches on the invert path
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pin_out_reg <= 2'b00;
            pin_oe_reg  <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                pin_out_reg[i] <= result[i];                                // RULE3 RULE4
                pin_oe_reg[i]  <= ctrl_reg[i].pin_drive_enable
                                  & ctrl_reg[i].enable & ~dir_reg[i];       // RULE8
            end
        end
    end
    assign pin_out = pin_out_reg;
    assign pin_oe  = pin_oe_reg;

    // port readback: analog pins always read zero
    assign port_value = pin_sync_reg & ~analog_reg;     // RULE14

    ////////////////////////////////////////////////////////////////////////////
    // mismatch latches: one per control access, one every cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            read_latch_reg <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                // writes count as reads; mirror reads never reach here
                if (ctrl_access[i]) begin
                    read_latch_reg[i] <= result[i];     // RULE16 RULE11
                end
            end
        end
    end

    // free-running sample latch and mismatch edge detect
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sample_latch_reg <= 2'b00;
            mismatch_d_reg   <= 2'b00;
        end else begin
            sample_latch_reg <= result;                 // RULE17
            mismatch_d_reg   <= mismatch;
        end
    end
    assign mismatch  = read_latch_reg ^ sample_latch_reg;
    assign irq_event = mismatch & ~mismatch_d_reg;      // RULE17

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status (write one to clear, a new event wins) and mask
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_status_reg <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (irq_event[i]) begin
                    irq_status_reg[i] <= 1'b1;          // RULE17
                end else if (wr_lane && avs_address == `CMP_OFS_IRQ_STATUS
                             && avs_writedata[i]) begin
                    irq_status_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_mask_reg <= `CMP_RST_IRQ_MASK;
        end else if (wr_lane && avs_address == `CMP_OFS_IRQ_MASK) begin
            irq_mask_reg <= avs_writedata[1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // read data, captured in the stall cycle; unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            readdata_reg <= 32'h0000_0000;
            unique case (avs_address)
                `CMP_OFS_CTRL_ONE: readdata_reg[7:0] <= ctrl_image(ctrl_reg[0], result[0]);
                `CMP_OFS_CTRL_TWO: readdata_reg[7:0] <= ctrl_image(ctrl_reg[1], result[1]);
                `CMP_OFS_MIRROR: begin
                    readdata_reg[`CMP_BIT_MIRROR_ONE] <= result[0];     // RULE10
                    readdata_reg[`CMP_BIT_MIRROR_TWO] <= result[1];     // RULE10
                    readdata_reg[`CMP_BIT_REFSEL_ONE] <= refsel_reg[0]; // RULE12
                    readdata_reg[`CMP_BIT_REFSEL_TWO] <= refsel_reg[1]; // RULE12
                    // low nibble stays zero                               RULE13
                end
                `CMP_OFS_IRQ_STATUS: readdata_reg[1:0] <= irq_status_reg;
                `CMP_OFS_IRQ_MASK:   readdata_reg[1:0] <= irq_mask_reg;
                `CMP_OFS_PIN_CFG: begin
                    readdata_reg[`CMP_BIT_DIR_LO +: 2]    <= dir_reg;
                    readdata_reg[`CMP_BIT_ANALOG_LO +: 2] <= analog_reg;
                end
                `CMP_OFS_PORT_READ: readdata_reg[1:0] <= port_value;    // RULE14
                default: readdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_pin_drive_gate: assert property (      // RULE8
        pin_oe[0] == $past(ctrl_reg[0].pin_drive_enable && ctrl_reg[0].enable && !dir_reg[0]))
        else $error("pin one driven without all three conditions");

    a_disabled_follows_pol: assert property (    // RULE18
        avs_read && !ack_reg && avs_address == `CMP_OFS_CTRL_TWO && !ctrl_reg[1].enable
        |=> avs_readdata[`CMP_BIT_RESULT] == $past(ctrl_reg[1].invert))
        else $error("disabled result does not follow invert bit");

    // compare against cmp_raw two edges back, not the synchroniser itself
    a_result_polarity: assert property (     // RULE2
        ctrl_reg[0].enable && $past(rstn) && $past(rstn, 2)
        |-> result[0] == ($past(cmp_raw[0], 2) ^ ctrl_reg[0].invert))
        else $error("result ignores polarity");

    // the flops hold reset values for two edges after release
    a_sync_two_stage: assert property (      // RULE19
        $past(rstn) && $past(rstn, 2) |-> raw_sync_reg == $past(cmp_raw, 2))
        else $error("synchroniser not two stages");

    a_latch_on_access: assert property (     // RULE16
        ctrl_access[0] |=> read_latch_reg[0] == $past(result[0]))
        else $error("mismatch latch missed control access");

    a_mirror_no_latch: assert property (     // RULE11
        accept && avs_address == `CMP_OFS_MIRROR |=> $stable(read_latch_reg))
        else $error("mirror read touched mismatch latch");

    a_irq_edge_only: assert property (       // RULE17
        mismatch[0] && mismatch_d_reg[0] |-> !irq_event[0])
        else $error("interrupt raised on mismatch level");

    a_irq_sets_status: assert property (     // RULE17
        irq_event[1] |=> irq_status_reg[1])
        else $error("mismatch edge lost");

    a_mirror_low_zero: assert property (     // RULE13
        avs_read && !ack_reg && avs_address == `CMP_OFS_MIRROR
        |=> avs_readdata[3:0] == 4'h0 && avs_readdata[7] == $past(result[0]))
        else $error("mirror read wrong");

    a_port_analog_zero: assert property (    // RULE14
        analog_reg[0] |-> !port_value[0])
        else $error("analog pin reads nonzero");

    a_wait_one_cycle: assert property (
        avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest longer than one cycle");

endmodule
`default_nettype wire

// ### src/dual_cmp_defines.svh
// register offsets, field positions, reset values for the dual comparator control
`ifndef DUAL_CMP_DEFINES_SVH
`define DUAL_CMP_DEFINES_SVH
`define CMP_OFS_CTRL_ONE    8'h00
`define CMP_OFS_CTRL_TWO    8'h04
`define CMP_OFS_MIRROR      8'h08
`define CMP_OFS_IRQ_STATUS  8'h0c
`define CMP_OFS_IRQ_MASK    8'h10
`define CMP_OFS_PIN_CFG     8'h14
`define CMP_OFS_PORT_READ   8'h18
`define CMP_BIT_ENABLE      7
`define CMP_BIT_RESULT      6
`define CMP_BIT_PIN_DRIVE   5
`define CMP_BIT_INVERT      4
`define CMP_BIT_SPEED       3
`define CMP_BIT_NONINV_SRC  2
`define CMP_BIT_CHAN_HI     1
`define CMP_BIT_CHAN_LO     0
`define CMP_BIT_MIRROR_ONE  7
`define CMP_BIT_MIRROR_TWO  6
`define CMP_BIT_REFSEL_ONE  5
`define CMP_BIT_REFSEL_TWO  4
`define CMP_BIT_DIR_LO      0
`define CMP_BIT_ANALOG_LO   2
`define CMP_RST_CTRL        7'h00
`define CMP_RST_REFSEL      2'h0
`define CMP_RST_IRQ_MASK    2'h0
`define CMP_RST_DIR         2'h3
`define CMP_RST_ANALOG      2'h3
`endif

// ### src/dual_cmp_pkg.sv
// types shared by the dual comparator control block
package dual_cmp_pkg;
    // writable fields of one comparator control register
    typedef struct packed {
        logic       enable;
        logic       pin_drive_enable;
        logic       invert;
        logic       speed_sel;
        logic       noninv_src_sel;
        logic [1:0] inv_channel_sel;
    } cmp_ctrl_s;
    // settings handed to one analog comparator and its muxes
    typedef struct packed {
        logic       enable;
        logic       speed_sel;
        logic       noninv_src_sel;
        logic       ref_source_sel;
        logic [1:0] inv_channel_sel;
    } cmp_cfg_s;
endpackage

// ### testbench/analog_pair_model.sv
// behavioural model of the two analog comparators and their input muxes
`timescale 1ns/1ps
`default_nettype none
module analog_pair_model import dual_cmp_pkg::*;
(
    input  wire logic        core_clk,    // only paces the idle wobble
    input  wire cmp_cfg_s    cfg_one,     // first comparator settings
    input  wire cmp_cfg_s    cfg_two,     // second comparator settings
    input  wire logic [15:0] noninv_pin,  // two noninverting pin levels
    input  wire logic [31:0] inv_pin,     // four shared inverting pin levels
    input  wire logic [7:0]  prog_ref,    // programmable reference level
    input  wire logic [7:0]  fixed_ref,   // fixed reference level
    output logic      [1:0]  cmp_raw      // raw comparator outputs
);
    logic       wobble = 1'b0;  // idle pattern
    logic [7:0] plus [2];
    logic [7:0] minus [2];
    cmp_cfg_s   cfg [2];
    ////////////////////////////////////////////////////////////////////////////
    // a switched-off comparator gives no trustworthy level, so it wobbles
    always @(posedge core_clk) begin
        wobble <= ~wobble;
    end
    // input routing and comparison
    always_comb begin
        cfg[0] = cfg_one;
        cfg[1] = cfg_two;
        for (int i = 0; i < 2; i++) begin
            plus[i] = cfg[i].noninv_src_sel ? (cfg[i].ref_source_sel ? prog_ref : fixed_ref)
                                            : noninv_pin[8*i +: 8];
            minus[i] = inv_pin[8*cfg[i].inv_channel_sel +: 8];
            cmp_raw[i] = cfg[i].enable ? (plus[i] > minus[i]) : (wobble ^ i[0]);
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_dual_comparator_control.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "dual_cmp_defines.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module tb_dual_comparator_control import dual_cmp_pkg::*;;
    logic        core_clk = 1'b0;        // 100 MHz
    logic        rstn = 1'b0;            // synchronous, active low
    logic [7:0]  avs_address = 8'h00;    // bus address
    logic        avs_read = 1'b0;        // read request
    logic        avs_write = 1'b0;       // write request
    logic [31:0] avs_writedata = 32'h0;  // write data
    logic [3:0]  avs_byteenable = 4'h1;  // byte lanes
    logic [31:0] avs_readdata;           // read data
    logic        avs_waitrequest;        // stall
    logic [1:0]  cmp_raw;                // model outputs
    cmp_cfg_s    cfg_one;                // first comparator settings
    cmp_cfg_s    cfg_two;                // second comparator settings
    logic [1:0]  pin_in;                 // resolved pin levels
    logic [1:0]  pin_out;                // design drive level
    logic [1:0]  pin_oe;                 // design drive enable
    logic [1:0]  pin_ext = 2'h3;         // external pull on the pins
    logic        irq;                    // interrupt line
    logic [15:0] noninv_pin = 16'h8080;  // both above low channels
    logic [31:0] inv_pin = 32'h90109010; // even channels low, odd high
    logic [7:0]  prog_ref = 8'h40;       // above channel zero
    logic [7:0]  fixed_ref = 8'h08;      // below channel zero
    logic [31:0] rd;                     // last read data
    int          mismatches = 0;
    int          total_checks = 0;
    int          cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #5 core_clk = ~core_clk;
    // whoever enables its driver owns the pin
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
    dual_comparator_control uut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmp_raw(cmp_raw), .cfg_one(cfg_one),
        .cfg_two(cfg_two), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
    analog_pair_model model (.core_clk(core_clk), .cfg_one(cfg_one), .cfg_two(cfg_two),
        .noninv_pin(noninv_pin), .inv_pin(inv_pin), .prog_ref(prog_ref),
        .fixed_ref(fixed_ref), .cmp_raw(cmp_raw));
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // whole run is about 500 cycles; a hang trips this
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            test_done;
        end
    end
    // one bus access, held until waitrequest is seen low at an edge
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_read      <= ~wr;
        avs_write     <= wr;
        // no cycle limit of its own: only the bench timeout ends a hang
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        `CHK("bus answer", 1'b0, avs_waitrequest)
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // covers synchroniser and registered pin latency with margin
    task automatic settle;
        repeat (6) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset_values;
        `CHK("cfg at reset", 12'h000, {cfg_one, cfg_two})
        for (int k = 0; k < 3; k++) begin
            bus_xfer(1'b0, 8'(k * 4), 8'h00);
            `CHK("register at reset", 32'h0, rd)
        end
        avs_byteenable <= 4'he;
        bus_xfer(1'b1, `CMP_OFS_CTRL_ONE, 8'hbf);
        avs_byteenable <= 4'h1;
        bus_xfer(1'b0, `CMP_OFS_CTRL_ONE, 8'h00);
        `CHK("lane disabled write", 32'h0, rd)
        bus_xfer(1'b1, `CMP_OFS_MIRROR, 8'hff);
        bus_xfer(1'b0, `CMP_OFS_MIRROR, 8'h00);
        `CHK("mirror low bits", 32'h30, rd)
        `CHK("refsel routing", 2'b11, {cfg_one.ref_source_sel, cfg_two.ref_source_sel})
        bus_xfer(1'b1, 8'h1c, 8'hff);
        bus_xfer(1'b0, 8'h1c, 8'h00);
        `CHK("unmapped read", 32'h0, rd)
    endtask
    // channel, polarity, enable, reference routing for comparator k
    task automatic s_compare(input int k);
        logic [7:0] a;
        logic       e;
        a = 8'(k * 4);
        bus_xfer(1'b1, `CMP_OFS_MIRROR, 8'h00);
        for (int m = 0; m < 8; m++) begin
            bus_xfer(1'b1, a, {3'b100, m[2], 2'b00, m[1:0]});
            e = ~m[0] ^ m[2];
            settle;
            bus_xfer(1'b0, a, 8'h00);
            `CHK("control readback", {24'h0, 1'b1, e, 1'b0, m[2], 2'b00, m[1:0]}, rd)
            bus_xfer(1'b0, `CMP_OFS_MIRROR, 8'h00);
            `CHK("mirror result", e, rd[7 - k])
        end
        // disabled: the result must follow invert, not the wobbling raw level
        bus_xfer(1'b1, a, 8'h3c);
        settle;
        bus_xfer(1'b0, a, 8'h00);
        `CHK("disabled result", 32'h7c, rd)
        `CHK("cfg fields", 6'b011000, (k == 1) ? cfg_two : cfg_one)
        for (int r = 0; r < 2; r++) begin
            bus_xfer(1'b1, `CMP_OFS_MIRROR, r[0] ? 8'h30 : 8'h00);
            bus_xfer(1'b1, a, 8'h84);
            settle;
            bus_xfer(1'b0, a, 8'h00);
            `CHK("internal reference", 32'h84 | (32'(r) << 6), rd)
        end
        bus_xfer(1'b1, a, 8'h00);
    endtask
    task automatic s_pins;
        bus_xfer(1'b1, `CMP_OFS_CTRL_ONE, 8'ha0);
        settle;
        `CHK("pin held as input", 1'b0, pin_oe[0])
        bus_xfer(1'b1, `CMP_OFS_PIN_CFG, 8'h02);
        settle;
        `CHK("pin enabled", 2'b01, pin_oe)
        `CHK("pin level", 1'b1, pin_out[0])
        bus_xfer(1'b1, `CMP_OFS_CTRL_ONE, 8'hb0);
        settle;
        `CHK("pin inverted", 1'b0, pin_out[0])
        bus_xfer(1'b1, `CMP_OFS_CTRL_ONE, 8'h80);
        settle;
        `CHK("pin internal only", 1'b0, pin_oe[0])
        bus_xfer(1'b1, `CMP_OFS_CTRL_ONE, 8'h20);
        settle;
        `CHK("pin while off", 1'b0, pin_oe[0])
        bus_xfer(1'b1, `CMP_OFS_PIN_CFG, 8'h07);
        settle;
        bus_xfer(1'b0, `CMP_OFS_PORT_READ, 8'h00);
        `CHK("analog pin reads zero", 32'h2, rd)
    endtask
    // move channel zero, then look at status and the line
    task automatic swing(input logic [7:0] lvl, input logic [31:0] exp);
        inv_pin[7:0] <= lvl;
        settle;
        bus_xfer(1'b0, `CMP_OFS_IRQ_STATUS, 8'h00);
        `CHK("irq status", exp, rd)
        `CHK("irq line", exp[0], irq)
    endtask
    task automatic s_irq;
        bus_xfer(1'b1, `CMP_OFS_CTRL_ONE, 8'h80);
        bus_xfer(1'b1, `CMP_OFS_IRQ_MASK, 8'h01);
        settle;
        bus_xfer(1'b1, `CMP_OFS_CTRL_ONE, 8'h80);
        bus_xfer(1'b1, `CMP_OFS_IRQ_STATUS, 8'h03);
        settle;
        `CHK("irq idle", 1'b0, irq)
        swing(8'h90, 32'h1);
        bus_xfer(1'b1, `CMP_OFS_IRQ_MASK, 8'h00);
        @(posedge core_clk);
        `CHK("irq masked", 1'b0, irq)
        bus_xfer(1'b1, `CMP_OFS_IRQ_MASK, 8'h01);
        bus_xfer(1'b1, `CMP_OFS_IRQ_STATUS, 8'h01);
        swing(8'h90, 32'h0);
        bus_xfer(1'b0, `CMP_OFS_MIRROR, 8'h00);
        swing(8'h10, 32'h0);
        swing(8'h90, 32'h1);
        bus_xfer(1'b1, `CMP_OFS_IRQ_STATUS, 8'h01);
        bus_xfer(1'b0, `CMP_OFS_CTRL_ONE, 8'h00);
        swing(8'h10, 32'h1);
    endtask
    task automatic s_mid_reset;
        bus_xfer(1'b1, `CMP_OFS_CTRL_TWO, 8'hbf);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        `CHK("cfg after reset", 12'h000, {cfg_one, cfg_two})
        bus_xfer(1'b0, `CMP_OFS_CTRL_TWO, 8'h00);
        `CHK("control after reset", 32'h0, rd)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        s_reset_values;
        s_compare(0);
        s_compare(1);
        s_pins;
        s_irq;
        s_mid_reset;
        test_done;
    end
endmodule
`default_nettype wire
